// [rtl/imc_mask_ctrl.sv]
// Interrupt mask control register and event gating onto the interrupt line
`timescale 1ns/1ps
`default_nettype none
module imc_mask_ctrl
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic soft_reset_req,
    input wire logic restart_req,
    input wire logic [6:0] acc_addr,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [15:0] acc_wdata,
    input wire imc_pkg::imc_events_t events,
    input wire logic devmode,
    input wire logic pending,
    output logic [15:0] acc_rdata_r,
    output logic acc_rvalid_r,
    output logic interrupt_out_n,
    output logic watchdog_enable_r,
    output logic [7:0] status_set_r,
    output logic [8:0] mask_out_r
);
    import imc_pkg::*;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_r;
    logic rst_n;

    // Asynchronous assert, two-stage synchronous release
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ****************************************************************
    // Mask register
    // ****************************************************************
    logic [8:0] mask_r;
    logic [8:0] mask_nxt;
    logic hit_wr;
    logic [6:0] gated;
    logic [IMC_Q_W-1:0] add_cnt_r;

    // Counts the enabled events of one cycle
    function automatic logic [IMC_Q_W-1:0] count_ones(input logic [6:0] v);
        logic [IMC_Q_W-1:0] n;
        n = '0;
        for (int i = 0; i < 7; i++)
            n = n + {{(IMC_Q_W-1){1'b0}}, v[i]};
        return n;
    endfunction : count_ones

    assign hit_wr = acc_wr && (acc_addr == IMC_ADDR_MASK);

    // Soft reset beats restart, restart beats a write
    always_comb
    begin
        mask_nxt = mask_r;
        if (soft_reset_req)
            mask_nxt = IMC_MASK_POR;
        else if (restart_req)
            mask_nxt = mask_r;
        else if (hit_wr)
            mask_nxt = acc_wdata[8:0]; // Upper bits have no storage
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_r <= IMC_MASK_POR;
        else
            mask_r <= mask_nxt;
    end

    // Mirror of the mask for the rest of the chip
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_out_r <= IMC_MASK_POR;
        else
            mask_out_r <= mask_nxt;
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    // Unmapped addresses answer zero rather than stale data
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_rdata_r <= '0;
            acc_rvalid_r <= 1'b0;
        end
        else
        begin
            acc_rvalid_r <= acc_rd;
            if (acc_rd && acc_addr == IMC_ADDR_MASK)
                acc_rdata_r <= {IMC_RES_VALUE, mask_r};
            else
                acc_rdata_r <= '0;
        end
    end

    // ****************************************************************
    // Event gating
    // ****************************************************************
    // Each event pulse is gated on its own, independent of status history
    always_comb
    begin
        gated[0] = events.supply && mask_r[IMC_BIT_SUPPLY];
        gated[1] = events.temp && mask_r[IMC_BIT_TEMP];
        gated[2] = events.bus && mask_r[IMC_BIT_BUS];
        gated[3] = events.high_side && mask_r[IMC_BIT_HIGH_SIDE];
        gated[4] = events.bridge && mask_r[IMC_BIT_BRIDGE];
        // Both failures together still count as one signal
        gated[5] = (events.spi_fail || events.crc_fail) && mask_r[IMC_BIT_SPI_CRC];
        gated[6] = events.wd_fail && devmode && mask_r[IMC_BIT_WDOG_IRQ];
    end

    // Number of pulses to queue this cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            add_cnt_r <= '0;
        else
            add_cnt_r <= count_ones(gated);
    end

    // Status sees every event whatever the mask says
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            status_set_r <= '0;
        else
            status_set_r <= events;
    end

    // Watchdog runs unless development mode and the off bit agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            watchdog_enable_r <= 1'b1;
        else
            watchdog_enable_r <= !(devmode && mask_r[IMC_BIT_WDOG_OFF]);
    end

    // ****************************************************************
    // Interrupt line
    // ****************************************************************
    imc_pulse_gen u_pulse
    (
        .clk(clk),
        .rst_n(rst_n),
        .add_cnt(add_cnt_r),
        .periodic_en(mask_r[IMC_BIT_PERIODIC]),
        .pending(pending),
        .irq_n_r(interrupt_out_n)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_write_only;
        hit_wr && !soft_reset_req && !restart_req;
    endsequence

    sequence s_lone_supply;
        events == imc_events_t'(8'h01);
    endsequence

    AST_RES_ZERO: assert property (acc_rvalid_r |-> acc_rdata_r[15:9] == 7'h00)
        else $error("Reserved bits read nonzero");
    AST_WRITE_LANDS: assert property (s_write_only |=> mask_r == $past(acc_wdata[8:0]))
        else $error("Mask write lost");
    AST_SOFT_LOAD: assert property (soft_reset_req |=> mask_r == IMC_MASK_POR)
        else $error("Soft reset value wrong");
    AST_RESTART_KEEP: assert property (restart_req && !soft_reset_req |=> $stable(mask_r))
        else $error("Restart changed low mask bits");
    AST_WDOG_OFF: assert property (devmode && mask_r[7] ##1 devmode && mask_r[7] |-> !watchdog_enable_r)
        else $error("Watchdog not disabled in development mode");
    AST_WDOG_NORMAL: assert property (!devmode |=> watchdog_enable_r)
        else $error("Watchdog off outside development mode");
    AST_SUPPLY_ON: assert property ((s_lone_supply and mask_r[0]) |=> add_cnt_r == 4'h1)
        else $error("Supply event not signalled");
    AST_SUPPLY_OFF: assert property ((s_lone_supply and !mask_r[0]) |=> add_cnt_r == 4'h0)
        else $error("Masked supply event signalled");
    AST_SPI_CRC_ONE: assert property (events == imc_events_t'(8'h60) && mask_r[5] |=> add_cnt_r == 4'h1)
        else $error("Serial failure not signalled once");
    AST_WD_DEVMODE: assert property (events == imc_events_t'(8'h80) && !devmode |=> add_cnt_r == 4'h0)
        else $error("Watchdog failure signalled outside development mode");
    AST_STATUS_KEPT: assert property (events != '0 |=> status_set_r == $past(events))
        else $error("Masked event not recorded");
endmodule : imc_mask_ctrl
`default_nettype wire

// [rtl/imc_pkg.sv]
// Package holding constants and types of the interrupt mask control
package imc_pkg;

    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam logic [6:0] IMC_ADDR_MASK = 7'h09;
    localparam int IMC_W = 16;
    localparam int IMC_RES_LO = 9;
    localparam int IMC_BIT_PERIODIC = 8;
    localparam int IMC_BIT_WDOG_OFF = 7;
    localparam int IMC_BIT_WDOG_IRQ = 6;
    localparam int IMC_BIT_SPI_CRC = 5;
    localparam int IMC_BIT_BRIDGE = 4;
    localparam int IMC_BIT_HIGH_SIDE = 3;
    localparam int IMC_BIT_BUS = 2;
    localparam int IMC_BIT_TEMP = 1;
    localparam int IMC_BIT_SUPPLY = 0;
    localparam logic [8:0] IMC_MASK_POR = 9'h140;
    localparam logic [6:0] IMC_RES_VALUE = 7'h00;

    // ****************************************************************
    // Timing of the interrupt line, 125 MHz clock
    // ****************************************************************
    localparam int IMC_CLK_PS = 8000;
    localparam int IMC_PULSE_NS = 2000;
    localparam int IMC_GAP_NS = 2000;
    localparam int IMC_PERIOD_US = 20;
    // Least times round up, the period rounds down
    localparam int IMC_PULSE_CYC = (IMC_PULSE_NS * 1000 + IMC_CLK_PS - 1) / IMC_CLK_PS;
    localparam int IMC_GAP_CYC = (IMC_GAP_NS * 1000 + IMC_CLK_PS - 1) / IMC_CLK_PS;
    localparam int IMC_PERIOD_CYC = (IMC_PERIOD_US * 1000000) / IMC_CLK_PS;
    localparam int IMC_CNT_W = 12;
    localparam int IMC_Q_W = 4;
    localparam logic [IMC_Q_W-1:0] IMC_Q_MAX = 4'hf;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic wd_fail;
        logic crc_fail;
        logic spi_fail;
        logic bridge;
        logic high_side;
        logic bus;
        logic temp;
        logic supply;
    } imc_events_t;

    typedef enum logic [1:0] {
        IMC_ST_IDLE = 2'b00,
        IMC_ST_LOW = 2'b01,
        IMC_ST_GAP = 2'b10
    } imc_state_t;

endpackage : imc_pkg

// [rtl/imc_pulse_gen.sv]
// Pulse generator driving the active-low interrupt line
`timescale 1ns/1ps
`default_nettype none
module imc_pulse_gen
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [imc_pkg::IMC_Q_W-1:0] add_cnt,
    input wire logic periodic_en,
    input wire logic pending,
    output logic irq_n_r
);
    import imc_pkg::*;

    imc_state_t state_r;
    logic [IMC_Q_W-1:0] queue_r;
    logic [IMC_CNT_W-1:0] cnt_r;
    logic [IMC_CNT_W-1:0] per_r;
    logic tick;
    logic take;
    logic [IMC_Q_W:0] sum;

    // Periodic re-signalling while anything stays pending
    assign tick = periodic_en && pending && (per_r == IMC_CNT_W'(IMC_PERIOD_CYC - 1));
    assign take = (state_r == IMC_ST_IDLE) && (queue_r != '0);
    assign sum = {1'b0, queue_r} + {1'b0, add_cnt} + {{IMC_Q_W{1'b0}}, tick} - {{IMC_Q_W{1'b0}}, take};

    // Period timer restarts whenever there is nothing to repeat
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            per_r <= '0;
        else if (!(periodic_en && pending) || tick)
            per_r <= '0;
        else
            per_r <= per_r + IMC_CNT_W'(1);
    end

    // Events are queued, up to 15 pending, so none is merged into another pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            queue_r <= '0;
        else if (sum > {1'b0, IMC_Q_MAX})
            queue_r <= IMC_Q_MAX; // Saturate; a burst above 15 loses the excess
        else
            queue_r <= sum[IMC_Q_W-1:0];
    end

    // Low pulse, then a high gap so the host sees separate edges
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= IMC_ST_IDLE;
            cnt_r <= '0;
            irq_n_r <= 1'b1;
        end
        else
        begin
            unique case (state_r)
                IMC_ST_IDLE:
                begin
                    if (take)
                    begin
                        state_r <= IMC_ST_LOW;
                        cnt_r <= '0;
                        irq_n_r <= 1'b0;
                    end
                end
                IMC_ST_LOW:
                begin
                    if (cnt_r == IMC_CNT_W'(IMC_PULSE_CYC - 1))
                    begin
                        state_r <= IMC_ST_GAP;
                        cnt_r <= '0;
                        irq_n_r <= 1'b1;
                    end
                    else
                        cnt_r <= cnt_r + IMC_CNT_W'(1);
                end
                IMC_ST_GAP:
                begin
                    if (cnt_r == IMC_CNT_W'(IMC_GAP_CYC - 1))
                    begin
                        state_r <= IMC_ST_IDLE;
                        cnt_r <= '0;
                    end
                    else
                        cnt_r <= cnt_r + IMC_CNT_W'(1);
                end
                default:
                begin
                    state_r <= IMC_ST_IDLE;
                    irq_n_r <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_low8;
        (!irq_n_r) [*8];
    endsequence

    AST_PULSE_HELD: assert property ($fell(irq_n_r) |-> s_low8)
        else $error("Interrupt pulse too short");
    AST_QUEUED_FIRES: assert property (take |=> !irq_n_r)
        else $error("Queued event did not pull the line low");
    AST_NO_PERIODIC: assert property (!periodic_en && add_cnt == '0 && !take |=> queue_r == $past(queue_r))
        else $error("Periodic pulse while disabled");
endmodule : imc_pulse_gen
`default_nettype wire

// [sim/imc_host_model.sv]
// Host-side model that watches the interrupt line and measures each pulse
`timescale 1ns/1ps
`default_nettype none
module imc_host_model
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic irq_n,
    output var int pulse_cnt,
    output var int low_len
);
    int run;

    // Count finished low pulses; a pulse counts when the line returns high
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            run <= 0;
            pulse_cnt <= 0;
            low_len <= 0;
        end
        else if (!irq_n)
        begin
            run <= run + 1;
        end
        else if (run != 0)
        begin
            pulse_cnt <= pulse_cnt + 1;
            low_len <= run;
            run <= 0;
        end
    end
endmodule : imc_host_model
`default_nettype wire

// [sim/interrupt_mask_control_tb_top.sv]
// Self-checking bench for the interrupt mask control block
`timescale 1ns/1ps
`default_nettype none
module interrupt_mask_control_tb_top;
    import imc_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, soft_reset_req = 1'b0, restart_req = 1'b0;
    logic acc_wr = 1'b0, acc_rd = 1'b0, devmode = 1'b0, pending = 1'b0;
    logic [6:0] acc_addr = 7'h00;
    logic [15:0] acc_wdata = 16'h0000;
    imc_events_t events = '0;
    logic [15:0] acc_rdata_r;
    logic acc_rvalid_r, interrupt_out_n, watchdog_enable_r;
    logic [7:0] status_set_r;
    logic [8:0] mask_out_r;
    int pulse_cnt, low_len, mismatches = 0, cmp_count = 0, seed = 42, exp_mask, c0, k, d;
    int cls[8] = '{0, 1, 2, 3, 4, 5, 5, 6};

    imc_mask_ctrl DUT (.clk(clk), .nrst(nrst), .soft_reset_req(soft_reset_req), .restart_req(restart_req),
        .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata), .events(events),
        .devmode(devmode), .pending(pending), .acc_rdata_r(acc_rdata_r), .acc_rvalid_r(acc_rvalid_r),
        .interrupt_out_n(interrupt_out_n), .watchdog_enable_r(watchdog_enable_r),
        .status_set_r(status_set_r), .mask_out_r(mask_out_r));
    imc_host_model host (.clk(clk), .nrst(nrst), .irq_n(interrupt_out_n), .pulse_cnt(pulse_cnt),
        .low_len(low_len));

    // 125 MHz clock
    initial
    begin
        forever #4 clk = ~clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task give_verdict;
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [6:0] a, input logic [15:0] v);
        @(posedge clk);
        acc_addr <= a;
        acc_wdata <= v;
        acc_wr <= 1'b1;
        @(posedge clk);
        acc_wr <= 1'b0;
        // Model keeps only the nine storage bits of the mask register
        if (a == IMC_ADDR_MASK)
            exp_mask = v & 16'h01ff;
    endtask : wr

    task rd(input logic [6:0] a, input logic [15:0] exp);
        int n;
        @(posedge clk);
        acc_addr <= a;
        acc_rd <= 1'b1;
        @(posedge clk);
        acc_rd <= 1'b0;
        #1;
        // Answer is due one cycle after the strobe; allow a little slack
        for (n = 0; n < 4 && acc_rvalid_r !== 1'b1; n++)
            @(posedge clk) #1;
        if (acc_rvalid_r !== 1'b1)
        begin
            mismatches++;
            give_verdict();
        end
        else
            chk(acc_rdata_r, exp);
    endtask : rd

    // Drive an event pattern for n back-to-back cycles, then count pulses
    task fire(input logic [7:0] v, input int n, input int exp_pulses);
        c0 = pulse_cnt;
        @(posedge clk);
        events <= imc_events_t'(v);
        repeat (n) @(posedge clk);
        events <= '0;
        #1;
        chk({8'h00, status_set_r}, {8'h00, v});
        repeat (1100) @(posedge clk);
        #1;
        chk(16'(pulse_cnt - c0), 16'(exp_pulses));
        if (exp_pulses > 0)
            chk(16'(low_len), 16'(IMC_PULSE_CYC));
    endtask : fire

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        exp_mask = 16'h0140;
        rd(IMC_ADDR_MASK, 16'h0140);
        // Random writes: reserved bits never read back
        for (k = 0; k < 6; k++)
        begin
            d = $random(seed);
            wr(IMC_ADDR_MASK, 16'(d));
            rd(IMC_ADDR_MASK, 16'(exp_mask));
        end
        wr(7'h0a, 16'hffff);
        rd(7'h0a, 16'h0000);
        rd(IMC_ADDR_MASK, 16'(exp_mask));
        // Watchdog switch in development mode: the off bit stops the watchdog, clearing it restarts it
        devmode <= 1'b1;
        wr(IMC_ADDR_MASK, 16'h0080);
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, watchdog_enable_r}, 16'h0000);
        wr(IMC_ADDR_MASK, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, watchdog_enable_r}, 16'h0001);
        // Every class: enabled gives one pulse per event, masked gives none
        for (k = 0; k < 8; k++)
        begin
            wr(IMC_ADDR_MASK, 16'(1 << cls[k]));
            fire(8'(1 << k), 2, 2);
            wr(IMC_ADDR_MASK, 16'h0000);
            fire(8'(1 << k), 1, 0);
        end
        wr(IMC_ADDR_MASK, 16'h0020);
        fire(8'h60, 1, 1);
        devmode <= 1'b0;
        wr(IMC_ADDR_MASK, 16'h0040);
        fire(8'h80, 1, 0);
        // Periodic re-signalling while something stays pending
        wr(IMC_ADDR_MASK, 16'h0100);
        pending <= 1'b1;
        c0 = pulse_cnt;
        repeat (5300) @(posedge clk);
        chk(16'(pulse_cnt - c0 >= 2), 16'h0001);
        wr(IMC_ADDR_MASK, 16'h0000);
        repeat (600) @(posedge clk);
        c0 = pulse_cnt;
        repeat (5300) @(posedge clk);
        chk(16'(pulse_cnt - c0), 16'h0000);
        pending <= 1'b0;
        // Restart keeps low bits and drops a write in the same cycle
        wr(IMC_ADDR_MASK, 16'hfea5);
        @(posedge clk);
        restart_req <= 1'b1;
        acc_wr <= 1'b1;
        acc_wdata <= 16'h0000;
        @(posedge clk);
        restart_req <= 1'b0;
        acc_wr <= 1'b0;
        rd(IMC_ADDR_MASK, 16'h00a5);
        chk({7'h00, mask_out_r}, 16'h00a5);
        @(posedge clk);
        soft_reset_req <= 1'b1;
        @(posedge clk);
        soft_reset_req <= 1'b0;
        rd(IMC_ADDR_MASK, 16'h0140);
        give_verdict();
    end

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule : interrupt_mask_control_tb_top
`default_nettype wire
